// ==== design/cpu_core_defines.vh ====
// Constants shared by the processor core state files.
`ifndef CPU_CORE_DEFINES_VH
`define CPU_CORE_DEFINES_VH
// Status word bit positions.
`define PSW_CARRY      0
`define PSW_PARITY     2
`define PSW_HALF       4
`define PSW_ZERO       6
`define PSW_SIGN       7
`define PSW_STEP       8
`define PSW_IEN        9
`define PSW_DIR        10
`define PSW_OVF        11
// Reserved bits read as this fixed pattern.
`define PSW_RSVD_MASK  16'hF02A
`define PSW_RSVD_VAL   16'hF002
`define PSW_RESET      16'hF002
// Register port addresses (word index).
`define ADDR_GEN0      5'h00
`define ADDR_SEG0      5'h08
`define ADDR_IP        5'h0C
`define ADDR_PSW       5'h0D
`define ADDR_PHYS      5'h0E
`define ADDR_ALU_RES   5'h0F
`define ADDR_EVT       5'h10
// General register indices.
`define GR_ACC         3'h0
`define GR_COUNT       3'h1
`define GR_DATA        3'h2
`define GR_BASE        3'h3
`define GR_SP          3'h4
`define GR_BP          3'h5
`define GR_SI          3'h6
`define GR_DI          3'h7
// Segment register indices.
`define SEG_EXTRA      2'h0
`define SEG_CODE       2'h1
`define SEG_STACK      2'h2
`define SEG_DATA       2'h3
// Operation codes, then the segment shift count.
`define OP_ADD         3'h0
`define OP_ADC         3'h1
`define OP_SUB         3'h2
`define OP_SBB         3'h3
`define OP_AND         3'h4
`define OP_OR          3'h5
`define OP_XOR         3'h6
`define SEG_SHIFT      4
`endif

// ==== design/phys_addr_gen.v ====
// Physical address former: segment shifted left four plus offset.
`timescale 1ns/100ps
`include "cpu_core_defines.vh"
module phys_addr_gen #(
    parameter SEG_W  = 16,
    parameter ADDR_W = 20
) (
    // Inputs.
    input  wire [SEG_W-1:0]  segment_val,
    input  wire [SEG_W-1:0]  offset_val,
    // Output.
    output wire [ADDR_W-1:0] phys_addr
);
    // The shifted segment and zero-extended offset add into 20 bits.
    wire [ADDR_W-1:0] seg_shifted;
    assign seg_shifted = {segment_val, {`SEG_SHIFT{1'b0}}};
    assign phys_addr   = seg_shifted + {{(ADDR_W-SEG_W){1'b0}}, offset_val};
endmodule

// ==== design/cpu_flags_and_address_gen.v ====
// Processor core state: status word, register set and address generation.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "cpu_core_defines.vh"
module cpu_flags_and_address_gen #(
    parameter DATA_W = 16,
    parameter ADDR_W = 20
) (
    // Clock and reset.
    input  wire              core_clk,
    input  wire              reset,
    // Register port.
    input  wire [4:0]        reg_addr,
    input  wire [15:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [15:0]       reg_rdata,
    // Arithmetic request.
    input  wire              alu_go,
    input  wire [2:0]        alu_op,
    input  wire              alu_byte,
    input  wire [2:0]        alu_dst,
    input  wire [2:0]        alu_src,
    input  wire              alu_hi_byte,
    // Memory reference request.
    input  wire              mem_go,
    input  wire [1:0]        mem_mode,
    input  wire              mem_override,
    input  wire [1:0]        mem_seg_sel,
    input  wire [2:0]        mem_base_sel,
    input  wire              mem_base_en,
    input  wire [2:0]        mem_index_sel,
    input  wire              mem_index_en,
    input  wire [15:0]       mem_disp,
    // Instruction sequencing.
    input  wire              instr_done,
    input  wire [15:0]       instr_len,
    input  wire              irq_req,
    input  wire              irq_take,
    input  wire [15:0]       irq_vector,
    input  wire              interrupt_return_op_go,
    input  wire [15:0]       interrupt_return_op_psw,
    input  wire [15:0]       interrupt_return_op_ip,
    // Outputs.
    output reg  [ADDR_W-1:0] addr_out,
    output reg               addr_valid,
    output reg  [15:0]       psw_out,
    output reg  [15:0]       push_data,
    output reg               push_valid,
    output reg               irq_accept,
    output reg               trace_trap
);
    // Memory reference modes.
    localparam MODE_DATA   = 2'h0;
    localparam MODE_CODE   = 2'h1;
    localparam MODE_STACK  = 2'h2;
    localparam MODE_STRING = 2'h3;
    // Trap sequencer states.
    localparam ST_IDLE  = 2'h0;
    localparam ST_PUSH  = 2'h1;
    localparam ST_CLEAR = 2'h2;

    // General registers, segment registers and pointers.
    reg [DATA_W-1:0] gen_q [0:7];
    reg [DATA_W-1:0] seg_q [0:3];
    reg [DATA_W-1:0] ip_q;
    reg [15:0]       psw_q;
    reg [DATA_W-1:0] res_q;
    reg [1:0]        st_q;
    reg              step_pend_q;
    integer          i;

    // Parity of a byte: one when the count of ones is even.
    function even_par;
        input [7:0] v;
        begin
            even_par = ~^v;
        end
    endfunction

    // Read one operand, byte halves for any of the eight registers.
    function [15:0] rd_op;
        input [2:0]  idx;
        input        byte_m;
        input        hi;
        input [15:0] val;
        begin
            if (byte_m) begin
                rd_op = hi ? {8'h00, val[15:8]} : {8'h00, val[7:0]};
            end else begin
                rd_op = val;
            end
        end
    endfunction

    // Status word with reserved bits forced.
    function [15:0] fix_psw;
        input [15:0] v;
        begin
            fix_psw = (v & ~`PSW_RSVD_MASK) | `PSW_RSVD_VAL;
        end
    endfunction

    // Arithmetic operand and result computation.
    reg [15:0] op_a;
    reg [15:0] op_b;
    reg [16:0] sum;
    reg [4:0]  nib;
    reg [15:0] res;
    reg        cout;
    reg        ovf;
    reg        msb;
    reg        cin;
    reg        sub_m;
    always @* begin
        op_a  = rd_op(alu_dst, alu_byte, alu_hi_byte, gen_q[alu_dst]);
        op_b  = rd_op(alu_src, alu_byte, 1'b0, gen_q[alu_src]);
        sub_m = (alu_op == `OP_SUB) || (alu_op == `OP_SBB);
        cin   = ((alu_op == `OP_ADC) || (alu_op == `OP_SBB)) & psw_q[`PSW_CARRY];
        sum   = 17'h00000;
        nib   = 5'h00;
        case (alu_op)
            `OP_ADD, `OP_ADC: begin
                sum = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, cin};
                nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
            end
            `OP_SUB, `OP_SBB: begin
                sum = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, cin};
                nib = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
            end
            `OP_AND: sum = {1'b0, op_a & op_b};
            `OP_OR:  sum = {1'b0, op_a | op_b};
            `OP_XOR: sum = {1'b0, op_a ^ op_b};
            default: sum = {1'b0, op_a};
        endcase
        res  = alu_byte ? {8'h00, sum[7:0]} : sum[15:0];
        // Carry or borrow out of the top bit of the operand size.
        cout = alu_byte ? (sum[8] ^ op_a[8] ^ op_b[8]) : sum[16];
        msb  = alu_byte ? res[7] : res[15];
        // Signed overflow: operand signs agree (add) or differ (sub) and result flips.
        if (alu_byte) begin
            ovf = sub_m ? ((op_a[7] ^ op_b[7]) & (op_a[7] ^ res[7]))
                        : (~(op_a[7] ^ op_b[7]) & (op_a[7] ^ res[7]));
        end else begin
            ovf = sub_m ? ((op_a[15] ^ op_b[15]) & (op_a[15] ^ res[15]))
                        : (~(op_a[15] ^ op_b[15]) & (op_a[15] ^ res[15]));
        end
    end

    // Memory reference offset and segment selection.
    reg [15:0] eff_off;
    reg [1:0]  seg_idx;
    wire [ADDR_W-1:0] phys;
    always @* begin
        eff_off = mem_disp;
        seg_idx = `SEG_DATA;
        case (mem_mode)
            MODE_CODE: begin
                eff_off = ip_q;
                seg_idx = `SEG_CODE;
            end
            MODE_STACK: begin
                // No override is honoured for stack pointer references.
                eff_off = gen_q[`GR_SP];
                seg_idx = `SEG_STACK;
            end
            MODE_STRING: begin
                eff_off = gen_q[`GR_DI];
                seg_idx = `SEG_EXTRA;
            end
            default: begin
                // Base and index registers build the operand offset.
                eff_off = mem_disp
                        + (mem_base_en ? gen_q[mem_base_sel] : 16'h0000)
                        + (mem_index_en ? gen_q[mem_index_sel] : 16'h0000);
                if (mem_override) begin
                    seg_idx = mem_seg_sel;
                end else if (mem_base_en && mem_base_sel == `GR_BP) begin
                    seg_idx = `SEG_STACK;
                end else begin
                    seg_idx = `SEG_DATA;
                end
            end
        endcase
    end

    // Segment value plus 16-bit offset feeds the address former.
    phys_addr_gen #(
        .SEG_W  (DATA_W),
        .ADDR_W (ADDR_W)
    ) i_phys_addr_gen (
        .segment_val (seg_q[seg_idx]),
        .offset_val  (eff_off),
        .phys_addr   (phys)
    );

    // String index step follows the direction bit.
    wire [15:0] str_step;
    assign str_step = psw_q[`PSW_DIR] ? 16'hFFFF : 16'h0001;
    wire [15:0] str_step_b;
    assign str_step_b = alu_byte ? str_step : {str_step[14:0], 1'b0};

    // Main state process: registers, flags and trap sequencing.
    always @(posedge core_clk) begin
        if (reset) begin
            for (i = 0; i < 8; i = i + 1) begin
                gen_q[i] <= 16'h0000;
            end
            for (i = 0; i < 4; i = i + 1) begin
                seg_q[i] <= 16'h0000;
            end
            ip_q        <= 16'h0000;
            psw_q       <= `PSW_RESET;
            res_q       <= 16'h0000;
            st_q        <= ST_IDLE;
            step_pend_q <= 1'b0;
            addr_out    <= {ADDR_W{1'b0}};
            addr_valid  <= 1'b0;
            push_data   <= 16'h0000;
            push_valid  <= 1'b0;
            irq_accept  <= 1'b0;
            trace_trap  <= 1'b0;
        end else begin
            addr_valid <= 1'b0;
            push_valid <= 1'b0;
            irq_accept <= 1'b0;
            trace_trap <= 1'b0;
            // Software writes to the register port.
            if (reg_wr) begin
                if (reg_addr < `ADDR_SEG0) begin
                    gen_q[reg_addr[2:0]] <= reg_wdata;
                end else if (reg_addr < `ADDR_IP) begin
                    seg_q[reg_addr[1:0]] <= reg_wdata;
                end else if (reg_addr == `ADDR_IP) begin
                    ip_q <= reg_wdata;
                end else if (reg_addr == `ADDR_PSW) begin
                    psw_q <= fix_psw(reg_wdata);
                end
            end
            // Arithmetic result and flag update.
            if (alu_go) begin
                res_q <= res;
                // Every operation writes back, byte results into the chosen half.
                if (alu_byte) begin
                    if (alu_hi_byte) begin
                        gen_q[alu_dst][15:8] <= res[7:0];
                    end else begin
                        gen_q[alu_dst][7:0] <= res[7:0];
                    end
                end else begin
                    gen_q[alu_dst] <= res;
                end
                psw_q[`PSW_SIGN]   <= msb;
                psw_q[`PSW_ZERO]   <= (res == 16'h0000);
                psw_q[`PSW_PARITY] <= even_par(res[7:0]);
                // Logic operations clear carry and overflow; half carry is left
                // undefined there and simply driven to zero.
                psw_q[`PSW_HALF]   <= sub_m | (alu_op <= `OP_ADC) ? nib[4] : 1'b0;
                psw_q[`PSW_CARRY]  <= (alu_op <= `OP_SBB) ? cout : 1'b0;
                psw_q[`PSW_OVF]    <= (alu_op <= `OP_SBB) ? ovf : 1'b0;
            end
            // Memory reference: drive address, step string index.
            if (mem_go) begin
                addr_out   <= phys;
                addr_valid <= 1'b1;
                if (mem_mode == MODE_STRING) begin
                    gen_q[`GR_DI] <= gen_q[`GR_DI] + str_step_b;
                end
            end
            // Instruction completion advances the pointer and arms tracing.
            if (instr_done) begin
                ip_q <= ip_q + instr_len;
                if (psw_q[`PSW_STEP]) begin
                    step_pend_q <= 1'b1;
                end
            end
            // Interrupt return restores pointer and status word.
            if (interrupt_return_op_go) begin
                ip_q  <= interrupt_return_op_ip;
                psw_q <= fix_psw(interrupt_return_op_psw);
            end
            // Trap sequencer: push the status word, then clear the step bit.
            case (st_q)
                ST_IDLE: begin
                    if (step_pend_q) begin
                        step_pend_q <= 1'b0;
                        trace_trap  <= 1'b1;
                        st_q        <= ST_PUSH;
                    end else if (irq_req && irq_take && psw_q[`PSW_IEN]) begin
                        irq_accept <= 1'b1;
                        push_data  <= psw_q;
                        push_valid <= 1'b1;
                        ip_q       <= irq_vector;
                    end
                end
                ST_PUSH: begin
                    push_data  <= psw_q;
                    push_valid <= 1'b1;
                    st_q       <= ST_CLEAR;
                end
                ST_CLEAR: begin
                    psw_q[`PSW_STEP] <= 1'b0;
                    st_q             <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Read data one cycle after the strobe; peripherals live in memory space.
    always @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr < `ADDR_SEG0) begin
                reg_rdata <= gen_q[reg_addr[2:0]];
            end else if (reg_addr < `ADDR_IP) begin
                reg_rdata <= seg_q[reg_addr[1:0]];
            end else if (reg_addr == `ADDR_IP) begin
                reg_rdata <= ip_q;
            end else if (reg_addr == `ADDR_PSW) begin
                reg_rdata <= psw_q;
            end else if (reg_addr == `ADDR_PHYS) begin
                reg_rdata <= addr_out[15:0];
            end else if (reg_addr == `ADDR_ALU_RES) begin
                reg_rdata <= res_q;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Status word mirror output.
    always @(posedge core_clk) begin
        if (reset) begin
            psw_out <= `PSW_RESET;
        end else begin
            psw_out <= psw_q;
        end
    end
endmodule

// ==== verification/core_state_sva.sv ====
// Port-level assertions for the processor core state block.
`timescale 1ns/100ps
`include "cpu_core_defines.vh"
module core_state_sva #(
    parameter DATA_W = 16,
    parameter ADDR_W = 20
) (
    // Clock and reset.
    input wire        core_clk,
    input wire        reset,
    // Requests.
    input wire [4:0]  reg_addr,
    input wire        reg_rd,
    input wire        mem_go,
    input wire        instr_done,
    input wire        irq_req,
    input wire        irq_take,
    // Results.
    input wire [15:0] reg_rdata,
    input wire        addr_valid,
    input wire [15:0] psw_out,
    input wire [15:0] push_data,
    input wire        push_valid,
    input wire        irq_accept,
    input wire        trace_trap
);
    // All checks use the core clock and rest while reset is high.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Reserved status positions always show the fixed pattern.
    AST_PSW_RSVD: assert property ((psw_out & `PSW_RSVD_MASK) == `PSW_RSVD_VAL)
        else $error("reserved status bits changed");
    // A status read returns the same word that the status output shows.
    AST_PSW_READ: assert property (
        $past(reg_rd) && $past(reg_addr) == `ADDR_PSW |-> reg_rdata == psw_out)
        else $error("status read differs from status output");
    // An accepted request needs the enable bit and a taken request.
    AST_IRQ_GATE: assert property (
        irq_accept |-> psw_out[`PSW_IEN] && $past(irq_req) && $past(irq_take))
        else $error("interrupt accepted without enable");
    // Acceptance pushes the status word in the same cycle.
    AST_IRQ_PUSH: assert property (irq_accept |-> push_valid && push_data == psw_out)
        else $error("interrupt acceptance without status push");
    // A trace trap follows a completed instruction while stepping.
    AST_TRACE_CAUSE: assert property (
        trace_trap |-> $past(instr_done, 2) && psw_out[`PSW_STEP])
        else $error("trace trap without stepping instruction");
    // The pushed word still has the step bit, which clears only afterwards.
    AST_TRACE_PUSH: assert property (
        trace_trap |=> push_valid && push_data[`PSW_STEP] ##[1:2] !psw_out[`PSW_STEP])
        else $error("trace push order wrong");
    // Every memory reference yields an address in the next cycle.
    AST_ADDR_TAKEN: assert property (mem_go |=> addr_valid)
        else $error("address missing after reference");
    // No address appears without a reference.
    AST_ADDR_VALID: assert property (addr_valid |-> $past(mem_go))
        else $error("address without reference");

    // Main scenarios seen.
    COV_IRQ: cover property (irq_accept);
    COV_TRACE: cover property (trace_trap ##1 push_valid);
    COV_ADDR: cover property (addr_valid);
endmodule

bind cpu_flags_and_address_gen core_state_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_sva (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .mem_go(mem_go), .instr_done(instr_done), .irq_req(irq_req), .irq_take(irq_take),
    .reg_rdata(reg_rdata), .addr_valid(addr_valid), .psw_out(psw_out),
    .push_data(push_data), .push_valid(push_valid), .irq_accept(irq_accept),
    .trace_trap(trace_trap)
);

// ==== verification/test_cpu_flags_and_address_gen.sv ====
// Self-checking bench for the processor core state block.
`timescale 1ns/100ps
`include "cpu_core_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
$display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module test_cpu_flags_and_address_gen;
    // Stimulus, all driven from time zero.
    logic        core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic        alu_go = 1'b0, alu_byte = 1'b0, alu_hi_byte = 1'b0, mem_go = 1'b0;
    logic [2:0]  alu_op = 3'h0, alu_dst = 3'h0, alu_src = 3'h0;
    logic        mem_override = 1'b0, mem_base_en = 1'b0, mem_index_en = 1'b0;
    logic [1:0]  mem_mode = 2'h0, mem_seg_sel = 2'h0;
    logic [2:0]  mem_base_sel = 3'h0, mem_index_sel = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, mem_disp = 16'h0000, instr_len = 16'h0000;
    logic [15:0] irq_vector = 16'h0000, interrupt_return_op_psw = 16'h0000, interrupt_return_op_ip = 16'h0000;
    logic        instr_done = 1'b0, irq_req = 1'b0, irq_take = 1'b0, interrupt_return_op_go = 1'b0;
    // Design outputs.
    wire  [15:0] reg_rdata, psw_out, push_data;
    wire  [19:0] addr_out;
    wire         addr_valid, push_valid, irq_accept, trace_trap;
    // Model state, corner operands and counters.
    logic [15:0] gen [8], sg [4], ip, psw, v;
    logic [15:0] ca [5] = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h000F, 16'h007F};
    int          err_count = 0, checks_done = 0, k, n;

    cpu_flags_and_address_gen i_cpu_flags_and_address_gen (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_go(alu_go),
        .alu_op(alu_op), .alu_byte(alu_byte), .alu_dst(alu_dst), .alu_src(alu_src),
        .alu_hi_byte(alu_hi_byte), .mem_go(mem_go), .mem_mode(mem_mode),
        .mem_override(mem_override), .mem_seg_sel(mem_seg_sel), .mem_disp(mem_disp),
        .mem_base_sel(mem_base_sel), .mem_base_en(mem_base_en), .mem_index_en(mem_index_en),
        .mem_index_sel(mem_index_sel), .instr_done(instr_done), .instr_len(instr_len),
        .irq_req(irq_req), .irq_take(irq_take), .irq_vector(irq_vector), .interrupt_return_op_go(interrupt_return_op_go),
        .interrupt_return_op_psw(interrupt_return_op_psw), .interrupt_return_op_ip(interrupt_return_op_ip), .addr_out(addr_out), .addr_valid(addr_valid),
        .psw_out(psw_out), .push_data(push_data), .push_valid(push_valid),
        .irq_accept(irq_accept), .trace_trap(trace_trap)
    );

    // Free-running 100 MHz clock.
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // One-cycle register write, mirrored in the model.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        if (a < `ADDR_SEG0) gen[a[2:0]] = d;
        else if (a < `ADDR_IP) sg[a[1:0]] = d;
        else if (a == `ADDR_IP) ip = d;
        else psw = (d & ~`PSW_RSVD_MASK) | `PSW_RSVD_VAL;
    endtask

    // One-cycle register read; the data are compared in the following cycle.
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // Runs one operation after predicting its result and flags.
    task automatic alu(input logic [2:0] op, input logic bm, input logic hi,
                       input logic [2:0] d, input logic [2:0] s);
        logic [16:0] a, b, r;
        logic [15:0] f;
        int          w;
        w = bm ? 8 : 16;
        a = bm ? {9'h000, hi ? gen[d][15:8] : gen[d][7:0]} : {1'b0, gen[d]};
        b = bm ? {9'h000, gen[s][7:0]} : {1'b0, gen[s]};
        r = op < `OP_SUB ? a + b + {16'h0000, op == `OP_ADC && psw[0]}
          : op < `OP_AND ? a - b - {16'h0000, op == `OP_SBB && psw[0]}
          : op == `OP_AND ? a & b : op == `OP_OR ? a | b : a ^ b;
        f = 16'h0000;
        f[`PSW_CARRY]  = op < `OP_AND && r[w];
        f[`PSW_HALF]   = op < `OP_AND && (a[4] ^ b[4] ^ r[4]);
        f[`PSW_OVF]    = op < `OP_AND && r[w-1] != a[w-1] && (a[w-1] == b[w-1]) == (op < `OP_SUB);
        f[`PSW_SIGN]   = r[w-1];
        f[`PSW_ZERO]   = (r[15:0] & (bm ? 16'h00FF : 16'hFFFF)) == 16'h0000;
        f[`PSW_PARITY] = ~^r[7:0];
        psw = (psw & ~16'h08D5) | f;
        if (!bm) gen[d] = r[15:0];
        else if (hi) gen[d][15:8] = r[7:0];
        else gen[d][7:0] = r[7:0];
        @(posedge core_clk);
        {alu_op, alu_byte, alu_hi_byte, alu_dst, alu_src} <= {op, bm, hi, d, s};
        alu_go <= 1'b1;
        @(posedge core_clk);
        alu_go <= 1'b0;
    endtask

    // Loads operands, runs one operation, checks destination and status.
    task automatic alu_case(input logic [2:0] op, input logic bm, input logic hi,
                            input logic [2:0] d, input logic [2:0] s,
                            input logic [15:0] va, input logic [15:0] vb);
        wr({2'b00, d}, va);
        wr({2'b00, s}, bm ? {vb[7:0], vb[7:0]} : vb);
        alu(op, bm, hi, d, s);
        rd({2'b00, d}, gen[d]);
        rd(`ADDR_PSW, psw);
        rd(`ADDR_ALU_RES, bm ? {8'h00, hi ? gen[d][15:8] : gen[d][7:0]} : gen[d]);
        `CHK(psw_out, psw)
    endtask

    // One memory reference; bit 3 of base and index selects enable.
    task automatic mem(input logic [1:0] m, input logic ov, input logic [1:0] ss,
                       input logic [3:0] bs, input logic [3:0] xs, input logic [15:0] dp);
        logic [15:0] sv, off, st;
        sv = m == 2'h1 ? sg[`SEG_CODE] : m == 2'h2 ? sg[`SEG_STACK] : m == 2'h3 ? sg[`SEG_EXTRA]
           : ov ? sg[ss] : bs == {1'b1, `GR_BP} ? sg[`SEG_STACK] : sg[`SEG_DATA];
        st = alu_byte ? 16'h0001 : 16'h0002;
        off = m == 2'h1 ? ip : m == 2'h2 ? gen[`GR_SP] : m == 2'h3 ? gen[`GR_DI]
            : (bs[3] ? gen[bs[2:0]] : 16'h0) + (xs[3] ? gen[xs[2:0]] : 16'h0) + dp;
        @(posedge core_clk);
        {mem_mode, mem_override, mem_seg_sel, mem_disp} <= {m, ov, ss, dp};
        {mem_base_en, mem_base_sel, mem_index_en, mem_index_sel} <= {bs, xs};
        mem_go <= 1'b1;
        @(posedge core_clk);
        mem_go <= 1'b0;
        #1;
        `CHK(addr_out, {sv, 4'h0} + {4'h0, off})
        `CHK(addr_valid, 1'b1)
        if (m == 2'h3) gen[`GR_DI] = psw[`PSW_DIR] ? gen[`GR_DI] - st : gen[`GR_DI] + st;
    endtask

    // Completes one instruction of the given length.
    task automatic done_instr(input logic [15:0] len);
        @(posedge core_clk);
        {instr_len, instr_done} <= {len, 1'b1};
        @(posedge core_clk);
        instr_done <= 1'b0;
        ip = ip + len;
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        void'($urandom(63096));
        psw = `PSW_RESET;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(`ADDR_PSW, `PSW_RESET);
        wr(`ADDR_PSW, 16'hFFFF);
        rd(`ADDR_PSW, psw);
        rd(5'h1F, 16'h0000);
        for (k = 0; k < 13; k++) wr(k[4:0], 16'($urandom));
        for (k = 0; k < 8; k++) rd(k[4:0], gen[k]);
        for (k = 0; k < 4; k++) rd(k[4:0] + `ADDR_SEG0, sg[k]);
        $display("register test done");
        for (n = 0; n < 10; n++)
            for (k = 0; k < 7; k++) alu_case(k[2:0], n >= 5, 1'b0, 3'h0, 3'h1, ca[n % 5], 16'h1);
        for (n = 0; n < 60; n++) begin
            v = 16'($urandom);
            alu_case(3'($urandom % 7), v[0], v[1], v[0] ? {1'b0, v[3:2]} : v[4:2],
                     v[0] ? {1'b0, v[6:5]} : v[7:5], 16'($urandom), 16'($urandom));
        end
        $display("arithmetic test done");
        wr(`ADDR_SEG0 + 5'(`SEG_DATA), 16'h12A4);
        mem(2'h0, 1'b0, 2'h0, 4'h0, 4'h0, 16'h0022);
        `CHK(addr_out, 20'h12A62)
        rd(`ADDR_PHYS, 16'h2A62);
        for (n = 0; n < 40; n++) begin
            v = 16'($urandom);
            alu_byte <= v[11];
            wr(`ADDR_PSW, v & 16'h0400);
            mem(v[1:0], v[2], v[4:3], {v[7], v[8] ? `GR_BASE : `GR_BP},
                {v[9], v[10] ? `GR_SI : `GR_DI}, 16'($urandom));
            if (v[1:0] == 2'h3) rd(5'(`GR_DI), gen[`GR_DI]);
        end
        done_instr(16'h0003);
        done_instr(16'hFFFF);
        rd(`ADDR_IP, ip);
        $display("address test done");
        wr(`ADDR_PSW, 16'h0000);
        {irq_vector, irq_req, irq_take} <= {16'($urandom), 2'b11};
        repeat (3) begin
            @(posedge core_clk);
            #1;
            `CHK(irq_accept, 1'b0)
        end
        {irq_req, irq_take} <= 2'b00;
        wr(`ADDR_PSW, 16'h0200);
        {irq_req, irq_take} <= 2'b11;
        @(posedge core_clk);
        {irq_req, irq_take} <= 2'b00;
        #1;
        `CHK(irq_accept, 1'b1)
        `CHK(push_data, psw)
        ip = irq_vector;
        rd(`ADDR_IP, ip);
        $display("interrupt test done");
        wr(`ADDR_PSW, 16'h0100);
        done_instr(16'h0002);
        for (k = 0; k < 6 && push_valid !== 1'b1; k++) @(posedge core_clk) #1;
        `CHK(push_data, psw)
        `CHK(push_valid, 1'b1)
        psw[`PSW_STEP] = 1'b0;
        repeat (2) @(posedge core_clk);
        rd(`ADDR_PSW, psw);
        @(posedge core_clk);
        {interrupt_return_op_psw, interrupt_return_op_ip, interrupt_return_op_go} <= {16'h0100, 16'h1234, 1'b1};
        @(posedge core_clk);
        interrupt_return_op_go <= 1'b0;
        {psw, ip} = {16'hF102, 16'h1234};
        rd(`ADDR_PSW, psw);
        rd(`ADDR_IP, ip);
        done_instr(16'h0001);
        for (k = 0; k < 4 && trace_trap !== 1'b1; k++) @(posedge core_clk) #1;
        `CHK(trace_trap, 1'b1)
        repeat (4) @(posedge core_clk);
        wr(`ADDR_PSW, 16'h0000);
        rd(`ADDR_PSW, psw);
        $display("trace test done");
        summarize();
    end

    // Watchdog: far beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        summarize();
    end
endmodule
